/* lsw_defs.svh */
// constants for the load switch control logic: offsets, fields, resets, timing
`ifndef LSW_DEFS_SVH
`define LSW_DEFS_SVH

// ==========================================
// register offsets
`define LSW_CTRL_ADDR       8'h00
`define LSW_STATUS_ADDR     8'h04

// ==========================================
// control fields and reset values
`define LSW_LOGIC_SEL_LSB   0
`define LSW_LOGIC_SEL_MSB   2
`define LSW_DELAY_SEL_LSB   3
`define LSW_DELAY_SEL_MSB   5
`define LSW_LOGIC_SEL_RST   3'h0
`define LSW_DELAY_SEL_RST   3'h0

// ==========================================
// status fields
`define LSW_ST_GATE_ON      0
`define LSW_ST_LOW_RANGE    1
`define LSW_ST_FAULT        2
`define LSW_ST_THERMAL_OFF  3
`define LSW_ST_SHORT_LIMIT  4
`define LSW_ST_DISCHARGE    5
`define LSW_ST_ENABLE       6

// ==========================================
// bus responses
`define LSW_RESP_OKAY       2'h0
`define LSW_RESP_SLVERR     2'h2

// ==========================================
// timing
`define LSW_CLK_PERIOD_PS   5000
`define LSW_TICK_PS         1000000
`define LSW_TICK_CYCLES     (`LSW_TICK_PS / `LSW_CLK_PERIOD_PS)
`define LSW_DELAY_2P5_US    2500
`define LSW_DELAY_5_US      5000
`define LSW_DELAY_50_US     50000
`define LSW_TICK_TO_US      1

`endif

/* lsw_pkg.sv */
// types shared by the load switch control logic
package lsw_pkg;

	// ==========================================
	// current range state
	typedef enum logic {
		LSW_RANGE_HIGH = 1'b0,
		LSW_RANGE_LOW  = 1'b1
	} lsw_range_t;

	// ==========================================
	// thermal state
	typedef enum logic {
		LSW_THERM_RUN = 1'b0,
		LSW_THERM_OFF = 1'b1
	} lsw_therm_t;

	// ==========================================
	// enable logic cell functions
	typedef enum logic [2:0] {
		LSW_FN_A_RANGE  = 3'h0,
		LSW_FN_AND      = 3'h1,
		LSW_FN_OR       = 3'h2,
		LSW_FN_XOR      = 3'h3,
		LSW_FN_NA_RANGE = 3'h4,
		LSW_FN_NAND     = 3'h5,
		LSW_FN_NOR      = 3'h6,
		LSW_FN_XNOR     = 3'h7
	} lsw_logic_fn_t;

	typedef logic [2:0]  lsw_delay_sel_t;
	typedef logic [15:0] lsw_tick_count_t;

endpackage : lsw_pkg

/* lsw_sync.sv */
// two-flop synchroniser for asynchronous pins and comparator flags
`timescale 1ns/10ps
module lsw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : lsw_sync

/* lsw_turn_on_delay.sv */
// turn-on delay of one enable input, counted in timebase ticks
`timescale 1ns/10ps
module lsw_turn_on_delay (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// timebase
	input  wire logic                     tick,
	// delay setting
	input  wire lsw_pkg::lsw_tick_count_t target,
	// enable input
	input  wire logic                     level_in,
	output logic                          level_out
);
	import lsw_pkg::*;

	lsw_tick_count_t count;

	// count reloads while the input is low; the rising edge alone is delayed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 16'h0000;
		end else if (!level_in) begin
			count <= 16'h0000;
		end else if (tick && count < target) begin
			count <= count + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_out <= 1'b0;
		end else begin
			level_out <= level_in && (count >= target);
		end
	end

endmodule : lsw_turn_on_delay

/* lsw_load_switch_ctrl.sv */
// load switch control logic: enable cell, turn-on delay, range, protection, bus slave
`include "lsw_defs.svh"
`timescale 1ns/10ps
module lsw_load_switch_ctrl #(
	parameter int TICK_CYCLES      = `LSW_TICK_CYCLES,
	parameter int DELAY_2P5_TICKS  = `LSW_DELAY_2P5_US / `LSW_TICK_TO_US,
	parameter int DELAY_5_TICKS    = `LSW_DELAY_5_US / `LSW_TICK_TO_US,
	parameter int DELAY_50_TICKS   = `LSW_DELAY_50_US / `LSW_TICK_TO_US
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// host pins
	input  wire logic        enable_input_a,
	input  wire logic        enable_b_or_range_select,
	// comparator flags
	input  wire logic        load_above_block_level,
	input  wire logic        load_above_trigger_level,
	input  wire logic        temp_above_limit,
	input  wire logic        temp_below_hysteresis,
	input  wire logic        output_below_500mv,
	// power stage controls
	output logic             gate_on,
	output logic             high_bank_enable,
	output logic             low_bank_enable,
	output logic             discharge_enable,
	output logic             short_limit_select,
	output logic             sense_gain_x8,
	output logic             fault_n
);
	import lsw_pkg::*;

	// ==========================================
	// functions
	function automatic logic range_mode(input lsw_logic_fn_t fn);
		range_mode = (fn == LSW_FN_A_RANGE) || (fn == LSW_FN_NA_RANGE);
	endfunction : range_mode

	function automatic lsw_tick_count_t delay_ticks(input logic [1:0] code);
		unique case (code)
			2'h0: delay_ticks = 16'h0000;
			2'h1: delay_ticks = DELAY_2P5_TICKS[15:0];
			2'h2: delay_ticks = DELAY_5_TICKS[15:0];
			2'h3: delay_ticks = DELAY_50_TICKS[15:0];
		endcase
	endfunction : delay_ticks

	function automatic logic cell_out(input lsw_logic_fn_t fn, input logic a, input logic b);
		unique case (fn)
			LSW_FN_A_RANGE:  cell_out = a;
			LSW_FN_AND:      cell_out = a & b;
			LSW_FN_OR:       cell_out = a | b;
			LSW_FN_XOR:      cell_out = a ^ b;
			LSW_FN_NA_RANGE: cell_out = ~a;
			LSW_FN_NAND:     cell_out = ~(a & b);
			LSW_FN_NOR:      cell_out = ~(a | b);
			LSW_FN_XNOR:     cell_out = ~(a ^ b);
		endcase
	endfunction : cell_out

	// ==========================================
	// synchronised inputs
	logic [6:0] pins_sync;
	logic       pin_a;
	logic       pin_b;
	logic       block_hit;
	logic       trigger_hit;
	logic       hot;
	logic       cooled;
	logic       low_vout;

	lsw_sync #(
		.WIDTH(7)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({output_below_500mv, temp_below_hysteresis, temp_above_limit,
			load_above_trigger_level, load_above_block_level,
			enable_b_or_range_select, enable_input_a}),
		.sync_out (pins_sync)
	);

	assign pin_a       = pins_sync[0];
	assign pin_b       = pins_sync[1];
	assign block_hit   = pins_sync[2];
	assign trigger_hit = pins_sync[3];
	assign hot         = pins_sync[4];
	assign cooled      = pins_sync[5];
	assign low_vout    = pins_sync[6];

	// ==========================================
	// configuration
	lsw_logic_fn_t  logic_sel;
	lsw_delay_sel_t delay_sel;

	// ==========================================
	// timebase
	logic [7:0] tick_div;
	logic       tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_div <= 8'h00;
			tick     <= 1'b0;
		end else if (tick_div == 8'(TICK_CYCLES - 1)) begin
			tick_div <= 8'h00;
			tick     <= 1'b1;
		end else begin
			tick_div <= tick_div + 8'h01;
			tick     <= 1'b0;
		end
	end

	// ==========================================
	// turn-on delay on the selected input
	logic a_delayed;
	logic b_delayed;

	lsw_turn_on_delay u_delay_a (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (tick),
		.target    (delay_sel[2] ? 16'h0000 : delay_ticks(delay_sel[1:0])),
		.level_in  (pin_a),
		.level_out (a_delayed)
	);

	lsw_turn_on_delay u_delay_b (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (tick),
		.target    (delay_sel[2] ? delay_ticks(delay_sel[1:0]) : 16'h0000),
		.level_in  (pin_b),
		.level_out (b_delayed)
	);

	// ==========================================
	// enable logic cell
	logic cell_enable;
	logic next_cell_enable;
	logic a_delayed_n;

	always_comb begin
		// inverted-a mode: delay acts on the asserting edge of the inverted input
		if (logic_sel == LSW_FN_NA_RANGE) begin
			next_cell_enable = !pin_a && a_delayed_n;
		end else begin
			next_cell_enable = cell_out(logic_sel, a_delayed, b_delayed);
		end
	end


	lsw_turn_on_delay u_delay_na (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (tick),
		.target    (delay_sel[2] ? 16'h0000 : delay_ticks(delay_sel[1:0])),
		.level_in  (!pin_a),
		.level_out (a_delayed_n)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cell_enable <= 1'b0;
		end else begin
			cell_enable <= next_cell_enable;
		end
	end

	// ==========================================
	// thermal protection
	lsw_therm_t therm;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			therm <= LSW_THERM_RUN;
		end else begin
			unique case (therm)
				LSW_THERM_RUN: begin
					if (hot) begin
						therm <= LSW_THERM_OFF;
					end
				end
				LSW_THERM_OFF: begin
					if (cooled && !hot) begin
						therm <= LSW_THERM_RUN;
					end
				end
			endcase
		end
	end

	// ==========================================
	// current range control
	lsw_range_t range;
	logic       range_pin_q;
	logic       range_rise;
	logic       range_sel;

	assign range_sel  = range_mode(logic_sel) && pin_b;
	assign range_rise = range_sel && !range_pin_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range_pin_q <= 1'b0;
		end else begin
			range_pin_q <= range_sel;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range <= LSW_RANGE_HIGH;
		end else begin
			unique case (range)
				LSW_RANGE_HIGH: begin
					if (range_rise && !block_hit) begin
						range <= LSW_RANGE_LOW;
					end
				end
				LSW_RANGE_LOW: begin
					if (trigger_hit || !range_sel) begin
						range <= LSW_RANGE_HIGH;
					end
				end
			endcase
		end
	end

	// refused request holds the error low until range select is released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_n <= 1'b1;
		end else if (range == LSW_RANGE_HIGH && range_rise && block_hit) begin
			fault_n <= 1'b0;
		end else if (!range_sel) begin
			fault_n <= 1'b1;
		end
	end

	// ==========================================
	// power stage outputs
	logic next_gate_on;

	assign next_gate_on = cell_enable && (therm == LSW_THERM_RUN) && !hot;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_on          <= 1'b0;
			discharge_enable <= 1'b1;
		end else begin
			gate_on          <= next_gate_on;
			discharge_enable <= !next_gate_on;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_bank_enable <= 1'b1;
			low_bank_enable  <= 1'b1;
			sense_gain_x8    <= 1'b0;
		end else begin
			high_bank_enable <= (range == LSW_RANGE_HIGH);
			low_bank_enable  <= 1'b1;
			sense_gain_x8    <= (range == LSW_RANGE_LOW);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_limit_select <= 1'b0;
		end else begin
			short_limit_select <= low_vout;
		end
	end

	// ==========================================
	// axi4-lite write channel
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        aw_full;
	logic        w_full;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LSW_RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			wr_addr       <= 8'h00;
			wr_data       <= 32'h0000_0000;
			wr_strb       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_full       <= 1'b1;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_full       <= 1'b1;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (aw_full && w_full && !s_axi_bvalid) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_addr == `LSW_CTRL_ADDR || wr_addr == `LSW_STATUS_ADDR)
					? `LSW_RESP_OKAY : `LSW_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			logic_sel <= lsw_logic_fn_t'(`LSW_LOGIC_SEL_RST);
			delay_sel <= `LSW_DELAY_SEL_RST;
		end else if (aw_full && w_full && !s_axi_bvalid && wr_addr == `LSW_CTRL_ADDR
			&& wr_strb[0]) begin
			logic_sel <= lsw_logic_fn_t'(wr_data[`LSW_LOGIC_SEL_MSB:`LSW_LOGIC_SEL_LSB]);
			delay_sel <= wr_data[`LSW_DELAY_SEL_MSB:`LSW_DELAY_SEL_LSB];
		end
	end

	// ==========================================
	// axi4-lite read channel
	logic [31:0] status_word;

	always_comb begin
		status_word                      = 32'h0000_0000;
		status_word[`LSW_ST_GATE_ON]     = gate_on;
		status_word[`LSW_ST_LOW_RANGE]   = (range == LSW_RANGE_LOW);
		status_word[`LSW_ST_FAULT]       = !fault_n;
		status_word[`LSW_ST_THERMAL_OFF] = (therm == LSW_THERM_OFF);
		status_word[`LSW_ST_SHORT_LIMIT] = short_limit_select;
		status_word[`LSW_ST_DISCHARGE]   = discharge_enable;
		status_word[`LSW_ST_ENABLE]      = cell_enable;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `LSW_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `LSW_RESP_OKAY;
			unique case (s_axi_araddr)
				`LSW_CTRL_ADDR: begin
					s_axi_rdata <= {26'h000_0000, delay_sel, logic_sel};
				end
				`LSW_STATUS_ADDR: begin
					s_axi_rdata <= status_word;
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `LSW_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : lsw_load_switch_ctrl

/* lsw_load_switch_ctrl_monitor.sv */
// port checker for the load switch control logic
`timescale 1ns/10ps
module lsw_load_switch_ctrl_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// comparator flags
	input wire logic load_above_block_level,
	input wire logic load_above_trigger_level,
	input wire logic temp_above_limit,
	input wire logic output_below_500mv,
	// power stage controls
	input wire logic gate_on,
	input wire logic high_bank_enable,
	input wire logic low_bank_enable,
	input wire logic discharge_enable,
	input wire logic short_limit_select,
	input wire logic sense_gain_x8,
	input wire logic fault_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================
	// properties
	property p_reset_range;
		$rose(aresetn) |-> high_bank_enable && low_bank_enable && !sense_gain_x8;
	endproperty
	a_reset_range: assert property (p_reset_range) else $error("no high range after reset");
	property p_therm;
		temp_above_limit [*6] |-> !gate_on;
	endproperty
	a_therm: assert property (p_therm) else $error("gate on while over temperature");
	property p_discharge;
		$fell(gate_on) |-> discharge_enable;
	endproperty
	a_discharge: assert property (p_discharge) else $error("turn-off without discharge");
	property p_gain;
		sense_gain_x8 != high_bank_enable;
	endproperty
	a_gain: assert property (p_gain) else $error("sense gain does not follow range");
	property p_block;
		load_above_block_level [*8] ##0 high_bank_enable |=> high_bank_enable;
	endproperty
	a_block: assert property (p_block) else $error("low range entered above block level");
	property p_fault;
		$fell(fault_n) |-> high_bank_enable && !sense_gain_x8;
	endproperty
	a_fault: assert property (p_fault) else $error("fault raised outside high range");
	property p_auto;
		load_above_trigger_level [*8] |-> high_bank_enable;
	endproperty
	a_auto: assert property (p_auto) else $error("no return to high range");
	property p_short;
		output_below_500mv [*6] |-> short_limit_select;
	endproperty
	a_short: assert property (p_short) else $error("short limit not selected");
	property p_normal;
		!output_below_500mv [*6] |-> !short_limit_select;
	endproperty
	a_normal: assert property (p_normal) else $error("short limit kept above 500 mV");
endmodule : lsw_load_switch_ctrl_monitor

bind lsw_load_switch_ctrl lsw_load_switch_ctrl_monitor u_lsw_load_switch_ctrl_monitor (
	.aclk(aclk), .aresetn(aresetn), .load_above_block_level(load_above_block_level),
	.load_above_trigger_level(load_above_trigger_level), .temp_above_limit(temp_above_limit),
	.output_below_500mv(output_below_500mv), .gate_on(gate_on), .fault_n(fault_n),
	.high_bank_enable(high_bank_enable), .low_bank_enable(low_bank_enable),
	.discharge_enable(discharge_enable), .short_limit_select(short_limit_select),
	.sense_gain_x8(sense_gain_x8)
);

/* lsw_host_model.sv */
// host model driving the enable and range pins
`timescale 1ns/10ps
module lsw_host_model (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// commands from the bench
	input  wire logic want_a,
	input  wire logic want_b,
	// switch state
	input  wire logic high_bank_enable,
	// pins
	output logic      enable_input_a,
	output logic      enable_b_or_range_select
);
	logic [2:0] supply_cnt;
	logic       high_seen;

	// ==========================================
	// supply ramp and high range seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_cnt <= 3'h0;
			high_seen  <= 1'h0;
		end else begin
			if (supply_cnt != 3'h7)
				supply_cnt <= supply_cnt + 3'h1;
			high_seen <= high_seen | high_bank_enable;
		end
	end

	// ==========================================
	// pins
	assign enable_input_a = want_a & (supply_cnt == 3'h7);
	assign enable_b_or_range_select = want_b & (supply_cnt == 3'h7) & high_seen;
endmodule : lsw_host_model

/* lsw_load_switch_ctrl_tb.sv */
// self-checking bench for the load switch control logic
`timescale 1ns/10ps
`include "lsw_defs.svh"
module lsw_load_switch_ctrl_tb;
	import lsw_pkg::*;
	localparam int         TICKS [4] = '{0, 3, 5, 8};
	localparam logic [3:0] TRUTH [8] = '{4'hC, 4'h8, 4'hE, 4'h6, 4'h3, 4'h7, 4'h1, 4'h9};
	logic        aclk, aresetn, want_a, want_b, enable_input_a, enable_b_or_range_select;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        load_above_block_level, load_above_trigger_level, temp_above_limit;
	logic        temp_below_hysteresis, output_below_500mv, gate_on, high_bank_enable;
	logic        low_bank_enable, discharge_enable, short_limit_select, sense_gain_x8, fault_n;
	int          n_errors = 0;
	int          n_tests = 0;

	// ==========================================
	// design and host model
	lsw_load_switch_ctrl #(.TICK_CYCLES(2), .DELAY_2P5_TICKS(3), .DELAY_5_TICKS(5),
		.DELAY_50_TICKS(8)) u_lsw_load_switch_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .enable_input_a(enable_input_a),
		.enable_b_or_range_select(enable_b_or_range_select), .gate_on(gate_on),
		.load_above_block_level(load_above_block_level), .temp_above_limit(temp_above_limit),
		.load_above_trigger_level(load_above_trigger_level), .fault_n(fault_n),
		.temp_below_hysteresis(temp_below_hysteresis), .output_below_500mv(output_below_500mv),
		.high_bank_enable(high_bank_enable), .low_bank_enable(low_bank_enable),
		.discharge_enable(discharge_enable), .short_limit_select(short_limit_select),
		.sense_gain_x8(sense_gain_x8));
	lsw_host_model u_lsw_host_model (.aclk(aclk), .aresetn(aresetn), .want_a(want_a),
		.want_b(want_b), .high_bank_enable(high_bank_enable), .enable_input_a(enable_input_a),
		.enable_b_or_range_select(enable_b_or_range_select));

	// ==========================================
	// common tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
		@(posedge aclk);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
		@(posedge aclk);
	endtask : rdr
	task automatic conclude;
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// ==========================================
	// scenarios
	task automatic t_reset;
		chk({high_bank_enable, low_bank_enable, sense_gain_x8, gate_on, fault_n}, 5'h19);
		rdr(`LSW_CTRL_ADDR);
		chk(rd, 32'h0000_0000);
		rdr(8'h0C);
		chk(resp, `LSW_RESP_SLVERR);
		wr(8'h0C, 32'h0000_003F);
		chk(resp, `LSW_RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(`LSW_CTRL_ADDR, 32'h0000_003F);
		chk(resp, `LSW_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdr(`LSW_CTRL_ADDR);
		chk(rd, 32'h0000_0000);
	endtask : t_reset
	task automatic t_logic;
		for (int f = 0; f < 8; f++) begin
			wr(`LSW_CTRL_ADDR, {29'h0, f[2:0]});
			for (int v = 0; v < 4; v++) begin
				want_a <= v[1];
				want_b <= v[0];
				cyc(10);
				chk(gate_on, TRUTH[f][v]);
				chk(discharge_enable, !TRUTH[f][v]);
			end
		end
	endtask : t_logic
	task automatic t_delay;
		int n;
		for (int d = 0; d < 8; d++) begin
			want_a <= 1'h0;
			want_b <= 1'h0;
			cyc(10);
			wr(`LSW_CTRL_ADDR, {26'h0, d[2:0], LSW_FN_AND});
			rdr(`LSW_CTRL_ADDR);
			chk(rd, {26'h0, d[2:0], LSW_FN_AND});
			want_a <= 1'h1;
			want_b <= 1'h1;
			n = 0;
			while (gate_on !== 1'h1 && n < 100) begin
				@(posedge aclk);
				n++;
			end
			chk(n >= 2 * TICKS[d % 4] && n <= 2 * TICKS[d % 4] + 10, 1'h1);
			want_a <= 1'h0;
			want_b <= 1'h0;
			n = 0;
			while (gate_on !== 1'h0 && n < 100) begin
				@(posedge aclk);
				n++;
			end
			chk(n <= 8, 1'h1);
			chk(discharge_enable, 1'h1);
		end
	endtask : t_delay
	task automatic t_range;
		wr(`LSW_CTRL_ADDR, 32'h0000_0000);
		want_a <= 1'h1;
		cyc(10);
		want_b <= 1'h1;
		cyc(10);
		chk({gate_on, high_bank_enable, sense_gain_x8, fault_n}, 4'hB);
		rdr(`LSW_STATUS_ADDR);
		chk(rd, 32'h0000_0043);
		load_above_trigger_level <= 1'h1;
		load_above_block_level <= 1'h1;
		cyc(10);
		chk({high_bank_enable, sense_gain_x8}, 2'h2);
		want_b <= 1'h0;
		load_above_trigger_level <= 1'h0;
		cyc(10);
		want_b <= 1'h1;
		cyc(10);
		chk({high_bank_enable, fault_n, gate_on}, 3'h5);
		rdr(`LSW_STATUS_ADDR);
		chk(rd, 32'h0000_0045);
		want_b <= 1'h0;
		load_above_block_level <= 1'h0;
		cyc(10);
		chk({high_bank_enable, fault_n}, 2'h3);
	endtask : t_range
	task automatic t_protect;
		for (int k = 0; k < 2; k++) begin
			temp_above_limit <= 1'h1;
			temp_below_hysteresis <= 1'h0;
			cyc(10);
			chk({gate_on, discharge_enable}, 2'h1);
			temp_above_limit <= 1'h0;
			cyc(10);
			chk(gate_on, 1'h0);
			temp_below_hysteresis <= 1'h1;
			cyc(10);
			chk(gate_on, 1'h1);
		end
		output_below_500mv <= 1'h1;
		cyc(10);
		chk(short_limit_select, 1'h1);
		output_below_500mv <= 1'h0;
		cyc(10);
		chk(short_limit_select, 1'h0);
	endtask : t_protect

	// ==========================================
	// clock, sequence and watchdog
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		aresetn <= 1'h0;
		{want_a, want_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= 18'h0;
		{load_above_block_level, load_above_trigger_level, temp_above_limit} <= 3'h0;
		{temp_below_hysteresis, output_below_500mv} <= 2'h2;
		s_axi_wdata <= 32'h0000_0000;
		s_axi_wstrb <= 4'hF;
		cyc(3);
		aresetn <= 1'h1;
		cyc(2);
		t_reset();
		t_logic();
		t_delay();
		t_range();
		t_protect();
		conclude();
	end
	initial begin
		#100us;
		n_errors++;
		conclude();
	end
endmodule : lsw_load_switch_ctrl_tb
